//--- hw/osd_pkg.sv
// osd_pkg: register map, field positions, reset values and types of the
// on-screen-display screen and plane control block.
// assumes a 32-bit AXI4-Lite register bus with one register per aligned word.
package osd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte addresses
  localparam int unsigned ADDR_W = 6;
  localparam logic [5:0] OFF_RASTER_PLANE_CONTROL = 6'h00;
  localparam logic [5:0] OFF_BORDER_COLOUR_SELECT = 6'h04;
  localparam logic [5:0] OFF_DISPLAY_CONTROL      = 6'h08;
  localparam logic [5:0] OFF_WINDOW_UPPER_LIMIT   = 6'h0C;
  localparam logic [5:0] OFF_WINDOW_LOWER_LIMIT   = 6'h10;
  localparam logic [5:0] OFF_AREA_PLANE_COLOUR    = 6'h14;
  localparam logic [5:0] OFF_EXTRA_CONTROL        = 6'h18;
  localparam logic [5:0] OFF_PORT_SIX_SELECT      = 6'h1C;
  localparam logic [5:0] OFF_SCAN_STATUS          = 6'h20;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int unsigned BIT_PAGE_BACKGROUND = 7;  // raster_plane_control
  localparam int unsigned BIT_FULL_RASTER     = 6;  // raster_plane_control
  localparam int unsigned BIT_PLANE_TWO_ON    = 5;  // raster_plane_control
  localparam int unsigned BIT_PLANE_ONE_ON    = 4;  // raster_plane_control
  localparam int unsigned BIT_DISPLAY_ENABLE  = 0;  // display_control
  localparam int unsigned BIT_WINDOW_ENABLE   = 1;  // display_control
  localparam int unsigned BIT_DOUBLE_SCAN     = 0;  // extra_control_register
  localparam int unsigned BIT_INTENSITY_PIN   = 6;  // extra_control_register
  localparam int unsigned BIT_LUMA_BLANK      = 2;  // port_six_select_register
  localparam int unsigned BIT_COLOUR_INT      = 3;  // intensity within a colour

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] RST_BYTE         = 8'h00;
  localparam logic [8:0] RST_WINDOW_UPPER = 9'h001;
  localparam logic [8:0] RST_WINDOW_LOWER = 9'h1FE;

  ////////////////////////////////////////////////////////////////////////////
  // scan line counter width and bus answers
  localparam int unsigned LINE_W   = 10;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;

  // colour code {intensity, red, green, blue}
  typedef logic [3:0] colour_t;

endpackage

//--- hw/pin_sync.sv
// pin_sync: three-stage synchroniser for pins from outside the clock domain.
// assumes the pins may change at any time; a new level is taken only once
// the second and third stages agree.
`timescale 1ns/1ns
module pin_sync #(
  parameter int unsigned WIDTH = 2
) (
  // clock, reset, enable
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             ce,
  // raw pins and filtered levels
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level
);
  import osd_pkg::*;

  logic [WIDTH-1:0] stage_one;
  logic [WIDTH-1:0] stage_two;
  logic [WIDTH-1:0] stage_three;

  // a filter with no pins cannot be built
  if (WIDTH == 0) begin : g_width_check
    $error("pin_sync needs a WIDTH of at least one");
  end

  // the synchronised pins idle high, as the sync pins are active low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage_one   <= '1;
      stage_two   <= '1;
      stage_three <= '1;
    end else if (ce) begin
      stage_one   <= pin;
      stage_two   <= stage_one;
      stage_three <= stage_two;
    end
  end

  // a bit changes only where the last two stages agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level <= '1;
    end else if (ce) begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage_two[i] == stage_three[i]) begin
          level[i] <= stage_three[i];
        end
      end
    end
  end

endmodule

//--- hw/osd_screen_plane_control.sv
// osd_screen_plane_control: page background, display on/off, vertical
// window, full-raster blanking and two area planes of an overlay generator.
// assumes the character generator feeds per-dot inputs on aclk and a TV
// mixer takes the registered colour and luma/blank outputs.
// Function
// [R1] background enable fills character area background
// [R2] no background on code-zero character cells
// [R3] background colour from border register bits 7:4
// [R4] colour code: intensity plus red green blue
// [R5] select bit drops intensity, eight colours
// [R6] display enable bit gates the page
// [R7] processor avoids stop mode while displaying
// [R8] window enable limits page between limits
// [R9] nine-bit limits, one sync period each
// [R10] double scan doubles each limit position
// [R11] software keeps lower above upper, upper nonzero
// [R12] software changes window only during vsync low
// [R13] recommended window upper 01H, lower 1FEH
// [R14] nothing drawn on the lower limit line
// [R15] full raster paints whole screen raster colour
// [R16] luma pin carries blank when selected
// [R17] raster colour from control bits 3:0
// [R18] two planes, plane one over plane two
// [R19] plane two bit 5, plane one bit 4
// [R20] plane colours from area colour nibbles
// [R21] fringe left of leading blank is drawn
// [R22] layers: characters, planes, background, raster
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns
module osd_screen_plane_control (
  // clock, reset, enable
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic                      ce,
  // axi4-lite write address and data
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [osd_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  // axi4-lite write response
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  output logic [1:0]                     s_axi_bresp,
  // axi4-lite read
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  input  wire logic [osd_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  // video sync pins, active low
  input  wire logic                      horizontal_sync_input_n,
  input  wire logic                      vertical_sync_input_n,
  // per-dot inputs from character and plane position logic
  input  wire logic                      char_area,
  input  wire logic                      char_code_zero,
  input  wire logic                      char_dot,
  input  wire osd_pkg::colour_t          char_colour,
  input  wire logic                      fringe_dot,
  input  wire logic                      plane_one_hit,
  input  wire logic                      plane_two_hit,
  // colour outputs to the video mixer
  output logic                           pix_intensity,
  output logic                           pix_red,
  output logic                           pix_green,
  output logic                           pix_blue,
  output logic                           luma_or_blank_output
);
  import osd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers and internal state
  logic [7:0]        raster_plane_control;
  logic [7:0]        border_colour_select;
  logic [7:0]        display_control;
  logic [8:0]        window_upper_limit;
  logic [8:0]        window_lower_limit;
  logic [7:0]        area_plane_colour;
  logic [7:0]        extra_control_register;
  logic [7:0]        port_six_select_register;
  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic [1:0]        sync_level;
  logic [1:0]        sync_prev;
  logic [LINE_W-1:0] line_count;
  logic              in_window;
  logic              do_write;

  // colour code with intensity dropped in eight-colour mode
  function automatic colour_t pick_colour(input colour_t code, input logic eight);
    pick_colour = code;
    if (eight) begin
      pick_colour[BIT_COLOUR_INT] = 1'b0;
    end
  endfunction

  // line at which a limit falls, doubled in double scan mode
  function automatic logic [LINE_W-1:0] limit_line(input logic [8:0] lim,
                                                   input logic dbl);
    limit_line = dbl ? {lim, 1'b0} : {1'b0, lim};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // axi write channel: address and data taken in either order
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // ready while the slot is free
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else if (ce) begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready);
    end
  end

  // write response, error on an unmapped address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OK;
    end else if (ce) begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        case (aw_addr)
          OFF_RASTER_PLANE_CONTROL, OFF_BORDER_COLOUR_SELECT, OFF_DISPLAY_CONTROL,
          OFF_WINDOW_UPPER_LIMIT, OFF_WINDOW_LOWER_LIMIT, OFF_AREA_PLANE_COLOUR,
          OFF_EXTRA_CONTROL, OFF_PORT_SIX_SELECT, OFF_SCAN_STATUS: begin
            s_axi_bresp <= RESP_OK;
          end
          default: begin
            s_axi_bresp <= RESP_ERR;
          end
        endcase
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register file, byte lane 0 holds bits 7:0 and lane 1 holds bit 8
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      raster_plane_control     <= RST_BYTE;
      border_colour_select     <= RST_BYTE;
      display_control          <= RST_BYTE;
      window_upper_limit       <= RST_WINDOW_UPPER;
      window_lower_limit       <= RST_WINDOW_LOWER;
      area_plane_colour        <= RST_BYTE;
      extra_control_register   <= RST_BYTE;
      port_six_select_register <= RST_BYTE;
    end else if (ce && do_write) begin
      case (aw_addr)
        OFF_RASTER_PLANE_CONTROL: begin
          if (w_strb[0]) raster_plane_control <= w_data[7:0];
        end
        OFF_BORDER_COLOUR_SELECT: begin
          if (w_strb[0]) border_colour_select <= w_data[7:0];
        end
        OFF_DISPLAY_CONTROL: begin
          if (w_strb[0]) display_control <= w_data[7:0];
        end
        OFF_WINDOW_UPPER_LIMIT: begin
          if (w_strb[0]) window_upper_limit[7:0] <= w_data[7:0];
          if (w_strb[1]) window_upper_limit[8] <= w_data[8];
        end
        OFF_WINDOW_LOWER_LIMIT: begin
          if (w_strb[0]) window_lower_limit[7:0] <= w_data[7:0];
          if (w_strb[1]) window_lower_limit[8] <= w_data[8];
        end
        OFF_AREA_PLANE_COLOUR: begin
          if (w_strb[0]) area_plane_colour <= w_data[7:0];
        end
        OFF_EXTRA_CONTROL: begin
          if (w_strb[0]) extra_control_register <= w_data[7:0];
        end
        OFF_PORT_SIX_SELECT: begin
          if (w_strb[0]) port_six_select_register <= w_data[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi read channel, one cycle from address to data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OK;
    end else if (ce) begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OK;
        s_axi_rdata  <= '0;
        case (s_axi_araddr)
          OFF_RASTER_PLANE_CONTROL: s_axi_rdata[7:0] <= raster_plane_control;
          OFF_BORDER_COLOUR_SELECT: s_axi_rdata[7:0] <= border_colour_select;
          OFF_DISPLAY_CONTROL:      s_axi_rdata[7:0] <= display_control;
          OFF_WINDOW_UPPER_LIMIT:   s_axi_rdata[8:0] <= window_upper_limit;
          OFF_WINDOW_LOWER_LIMIT:   s_axi_rdata[8:0] <= window_lower_limit;
          OFF_AREA_PLANE_COLOUR:    s_axi_rdata[7:0] <= area_plane_colour;
          OFF_EXTRA_CONTROL:        s_axi_rdata[7:0] <= extra_control_register;
          OFF_PORT_SIX_SELECT:      s_axi_rdata[7:0] <= port_six_select_register;
          OFF_SCAN_STATUS: begin
            s_axi_rdata[LINE_W-1:0] <= line_count;
            s_axi_rdata[16]         <= in_window;
            s_axi_rdata[17]         <= sync_level[1];
          end
          default: begin
            s_axi_rresp <= RESP_ERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sync pins: bit 0 horizontal, bit 1 vertical
  pin_sync #(
    .WIDTH (2)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .pin     ({vertical_sync_input_n, horizontal_sync_input_n}),
    .level   (sync_level)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_prev <= 2'h3;
    end else if (ce) begin
      sync_prev <= sync_level;
    end
  end

  // scan line count: cleared at vertical fall, stepped at horizontal fall
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_count <= '0;
    end else if (ce) begin
      if (sync_prev[1] && !sync_level[1]) begin
        line_count <= '0;
      end else if (sync_prev[0] && !sync_level[0] && !(&line_count)) begin
        line_count <= line_count + 1'b1;
      end
    end
  end

  // window: from upper line up to but not including the lower line
  always_comb begin
    in_window = 1'b1;
    if (display_control[BIT_WINDOW_ENABLE]) begin  // R8
      in_window = (line_count >= limit_line(window_upper_limit,  // R9 R10
                                            extra_control_register[BIT_DOUBLE_SCAN]))
               && (line_count < limit_line(window_lower_limit,  // R14
                                           extra_control_register[BIT_DOUBLE_SCAN]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dot composition, top layer first, registered onto the pins
  logic    eight_colour;
  logic    page_on;
  logic    raster_on;
  colour_t next_colour;
  logic    next_painted;
  logic    next_luma_blank;

  assign eight_colour = extra_control_register[BIT_INTENSITY_PIN];  // R5
  assign page_on      = display_control[BIT_DISPLAY_ENABLE] && in_window;  // R6
  assign raster_on    = display_control[BIT_DISPLAY_ENABLE]
                     && raster_plane_control[BIT_FULL_RASTER]  // R15
                     && port_six_select_register[BIT_LUMA_BLANK];  // R16

  always_comb begin
    next_colour  = '0;
    next_painted = 1'b1;
    if (page_on && char_dot) begin  // R22
      next_colour = pick_colour(char_colour, eight_colour);
    end else if (page_on && fringe_dot) begin  // R21
      next_colour = pick_colour(border_colour_select[3:0], eight_colour);
    end else if (page_on && plane_one_hit
                 && raster_plane_control[BIT_PLANE_ONE_ON]) begin  // R18 R19
      next_colour = pick_colour(area_plane_colour[3:0], eight_colour);  // R20
    end else if (page_on && plane_two_hit
                 && raster_plane_control[BIT_PLANE_TWO_ON]) begin  // R19
      next_colour = pick_colour(area_plane_colour[7:4], eight_colour);  // R20
    end else if (page_on && char_area && !char_code_zero  // R2
                 && raster_plane_control[BIT_PAGE_BACKGROUND]) begin  // R1
      next_colour = pick_colour(border_colour_select[7:4], eight_colour);  // R3 R4
    end else if (raster_on) begin
      next_colour = pick_colour(raster_plane_control[3:0], eight_colour);  // R17
    end else begin
      next_painted = 1'b0;
    end
    // luma marks only page dots; blank marks every painted dot
    next_luma_blank = next_painted
                   && (port_six_select_register[BIT_LUMA_BLANK] || !raster_on);  // R16
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pix_intensity        <= 1'b0;
      pix_red              <= 1'b0;
      pix_green            <= 1'b0;
      pix_blue             <= 1'b0;
      luma_or_blank_output <= 1'b0;
    end else if (ce) begin
      {pix_intensity, pix_red, pix_green, pix_blue} <= next_colour;
      luma_or_blank_output <= next_luma_blank;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks on the dot outputs
  logic [3:0] pix_all;
  assign pix_all = {pix_intensity, pix_red, pix_green, pix_blue};

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_display_off;
    ce && !display_control[BIT_DISPLAY_ENABLE] |=> pix_all == 4'h0 && !luma_or_blank_output;
  endproperty
  a_display_off: assert property (p_display_off) else $error("dot painted with display off"); // R6

  property p_background;
    ce && page_on && char_area && !char_code_zero && !char_dot && !fringe_dot
      && !plane_one_hit && !plane_two_hit && raster_plane_control[BIT_PAGE_BACKGROUND]
      && !eight_colour |=> pix_all == $past(border_colour_select[7:4]);
  endproperty
  a_background: assert property (p_background) else $error("background colour wrong"); // R1

  property p_code_zero;
    ce && char_code_zero && !char_dot && !fringe_dot && !plane_one_hit && !plane_two_hit
      && !raster_on |=> !luma_or_blank_output;
  endproperty
  a_code_zero: assert property (p_code_zero) else $error("code zero cell painted"); // R2

  property p_eight_colour;
    ce && eight_colour |=> !pix_intensity;
  endproperty
  a_eight_colour: assert property (p_eight_colour) else $error("intensity in 8-colour mode"); // R5

  property p_window_edge;
    ce && display_control[BIT_WINDOW_ENABLE] && line_count == limit_line(window_lower_limit,
      extra_control_register[BIT_DOUBLE_SCAN]) && !raster_on |=> !luma_or_blank_output;
  endproperty
  a_window_edge: assert property (p_window_edge) else $error("dot on lower limit line"); // R14

  property p_double_scan;
    ce && display_control[BIT_WINDOW_ENABLE] && extra_control_register[BIT_DOUBLE_SCAN]
      && line_count < {window_upper_limit, 1'b0} |-> !in_window;
  endproperty
  a_double_scan: assert property (p_double_scan) else $error("window open too early"); // R10

  property p_raster;
    ce && raster_on && !page_on && !eight_colour
      |=> pix_all == $past(raster_plane_control[3:0]) && luma_or_blank_output;
  endproperty
  a_raster: assert property (p_raster) else $error("raster colour wrong"); // R15

  property p_plane_priority;
    ce && page_on && !char_dot && !fringe_dot && plane_one_hit && plane_two_hit
      && raster_plane_control[BIT_PLANE_ONE_ON] && !eight_colour
      |=> pix_all == $past(area_plane_colour[3:0]);
  endproperty
  a_plane_priority: assert property (p_plane_priority) else $error("plane 2 over plane 1"); // R18

  property p_char_top;
    ce && page_on && char_dot && !eight_colour |=> pix_all == $past(char_colour);
  endproperty
  a_char_top: assert property (p_char_top) else $error("character not on top"); // R22

  c_background: cover property (ce && page_on && char_area
                                && raster_plane_control[BIT_PAGE_BACKGROUND]);
  c_raster:     cover property (ce && raster_on && !page_on);
  c_planes:     cover property (ce && page_on && plane_one_hit && plane_two_hit);

endmodule

//--- dv/tv_mixer_model.sv
// tv_mixer_model: stand-in for the tv side; makes the sync pins, takes the colour.
// assumes the bench calls its tasks from one process clocked by aclk.
`timescale 1ns/1ns
module tv_mixer_model (
  // clock
  input  wire logic       aclk,
  // colour and luma/blank from the block
  input  wire logic [3:0] pix,
  input  wire logic       luma_or_blank_output,
  // sync pins, active low
  output logic            horizontal_sync_input_n,
  output logic            vertical_sync_input_n
);
  // both sync pins idle high
  initial begin
    horizontal_sync_input_n = 1'b1;
    vertical_sync_input_n = 1'b1;
  end
  // one scan line: low then high, long enough to pass the pin filter
  task automatic hline();
    @(posedge aclk);
    horizontal_sync_input_n <= 1'b0;
    repeat (8) @(posedge aclk);
    horizontal_sync_input_n <= 1'b1;
    repeat (8) @(posedge aclk);
  endtask
  // frame sync level; a fall clears the line count
  task automatic vset(input logic v);
    @(posedge aclk);
    vertical_sync_input_n <= v;
    repeat (12) @(posedge aclk);
  endtask
endmodule

//--- dv/osd_screen_plane_control_test.sv
// osd_screen_plane_control_test: register and dot tests of the plane block.
// assumes an AXI4-Lite slave and dots shown one cycle after they are driven.
`timescale 1ns/1ns
`define CK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %0t %h %h", $time, g, e); end end
module osd_screen_plane_control_test;
  import osd_pkg::*;
  logic aclk, aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb, char_colour;
  wire logic [3:0] pix;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic horizontal_sync_input_n, vertical_sync_input_n, char_area, char_code_zero;
  logic char_dot, fringe_dot, plane_one_hit, plane_two_hit, luma_or_blank_output;
  int n_fail = 0, cmp_count = 0, i;
  osd_screen_plane_control u_dut (.aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .horizontal_sync_input_n,
    .vertical_sync_input_n, .char_area, .char_code_zero, .char_dot, .char_colour,
    .fringe_dot, .plane_one_hit, .plane_two_hit, .pix_intensity(pix[3]), .pix_red(pix[2]),
    .pix_green(pix[1]), .pix_blue(pix[0]), .luma_or_blank_output);
  tv_mixer_model u_tv (.aclk, .pix, .luma_or_blank_output, .horizontal_sync_input_n,
    .vertical_sync_input_n);
  ////////////////////////////////////////////////////////////////////////////
  // bus write: address and data offered together, each dropped when taken
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    bit ad = 0, wd = 0;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (s_axi_awready) begin ad = 1; s_axi_awvalid <= 0; end
      if (s_axi_wready) begin wd = 1; s_axi_wvalid <= 0; end
    end
    while (!s_axi_bvalid) @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  // bus read: data and response taken at the rvalid edge
  task automatic rd(input logic [5:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 0;
  endtask
  // one dot: {area, code zero, char, fringe, plane one, plane two}
  task automatic dot(input logic [5:0] v, input logic [3:0] c, input logic [3:0] e);
    @(posedge aclk);
    {char_area, char_code_zero, char_dot, fringe_dot, plane_one_hit, plane_two_hit} <= v;
    char_colour <= c;
    @(posedge aclk);
    #1 `CK(pix, e)
  endtask
  // five lines of a frame; window lines 2 and 3 show the character
  task automatic win();
    for (int k = 0; k < 5; k++) begin
      #1 `CK(pix, (k == 2 || k == 3) ? 4'h9 : 4'h0)
      u_tv.hline();
    end
  endtask
  task automatic end_sim();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    #300000;
    n_fail++;
    end_sim();
  end
  // main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, char_colour} = 0;
    {char_area, char_code_zero, char_dot, fringe_dot, plane_one_hit, plane_two_hit} = 0;
    ce = 1;
    s_axi_wstrb = 4'hF;
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    rd(OFF_RASTER_PLANE_CONTROL);
    `CK(d, 32'h0)
    rd(OFF_WINDOW_UPPER_LIMIT);
    `CK(d, 32'h1)
    rd(OFF_WINDOW_LOWER_LIMIT);
    `CK(d, 32'h1FE)
    rd(6'h24);
    `CK({d, r}, {32'h0, RESP_ERR})
    wr(6'h28, 32'h1);
    `CK(r, RESP_ERR)
    wr(OFF_WINDOW_LOWER_LIMIT, 32'hFFFFFFFF);
    rd(OFF_WINDOW_LOWER_LIMIT);
    `CK(d, 32'h1FF)
    wr(OFF_PORT_SIX_SELECT, 32'h4);
    wr(OFF_BORDER_COLOUR_SELECT, 32'hA6);
    wr(OFF_AREA_PLANE_COLOUR, 32'h3C);
    wr(OFF_RASTER_PLANE_CONTROL, 32'hF5);
    dot(6'h08, 4'h9, 4'h0);
    wr(OFF_DISPLAY_CONTROL, 32'h1);
    dot(6'h08, 4'h9, 4'h9);
    dot(6'h07, 4'h9, 4'h6);
    dot(6'h03, 4'h0, 4'hC);
    dot(6'h01, 4'h0, 4'h3);
    dot(6'h21, 4'h0, 4'h3);
    dot(6'h20, 4'h0, 4'hA);
    dot(6'h30, 4'h0, 4'h5);
    `CK(luma_or_blank_output, 1'b1)
    for (i = 0; i < 16; i++) begin
      wr(OFF_RASTER_PLANE_CONTROL, 32'h40 | i);
      dot(6'h00, 4'h0, i[3:0]);
    end
    wr(OFF_RASTER_PLANE_CONTROL, 32'hFF);
    wr(OFF_EXTRA_CONTROL, 32'h40);
    dot(6'h20, 4'h0, 4'h2);
    dot(6'h03, 4'h0, 4'h4);
    dot(6'h00, 4'h0, 4'h7);
    wr(OFF_RASTER_PLANE_CONTROL, 32'hEF);
    dot(6'h03, 4'h0, 4'h3);
    wr(OFF_RASTER_PLANE_CONTROL, 32'h80);
    dot(6'h30, 4'h0, 4'h0);
    `CK(luma_or_blank_output, 1'b0)
    wr(OFF_RASTER_PLANE_CONTROL, 32'h0);
    dot(6'h20, 4'h0, 4'h0);
    wr(OFF_EXTRA_CONTROL, 32'h0);
    u_tv.vset(1'b0);
    wr(OFF_WINDOW_UPPER_LIMIT, 32'h2);
    wr(OFF_WINDOW_LOWER_LIMIT, 32'h4);
    wr(OFF_DISPLAY_CONTROL, 32'h3);
    u_tv.vset(1'b1);
    dot(6'h08, 4'h9, 4'h0);
    win();
    rd(OFF_SCAN_STATUS);
    `CK(d, 32'h20005)
    u_tv.vset(1'b0);
    wr(OFF_WINDOW_UPPER_LIMIT, 32'h1);
    wr(OFF_WINDOW_LOWER_LIMIT, 32'h2);
    wr(OFF_EXTRA_CONTROL, 32'h1);
    u_tv.vset(1'b1);
    win();
    end_sim();
  end
endmodule
